// *** sac_pkg.sv ***
// sac_pkg: constants, types and register map of the 10-bit sar converter
// control block; assumes an apb master on pclk and an analog front end
// (sample switch, dac, comparator, channel mux) outside this block.
package sac_pkg;
    localparam int RES_BITS = 10;
    localparam int CHAN_BITS = 4;
    localparam int ADDR_BITS = 12;
    // printed offsets are not word aligned: kept as indices, byte = 4 * index
    localparam logic [7:0] IDX_CONTROL_STATUS = 8'h70;
    localparam logic [7:0] IDX_RESULT_HIGH = 8'h71;
    localparam logic [7:0] IDX_RESULT_LOW = 8'h72;
    localparam logic [7:0] IDX_PIN_LEVEL = 8'h73;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam int BIT_DONE = 7;
    localparam int BIT_SPEED = 6;
    localparam int BIT_ON = 5;
    localparam logic [1:0] DIV_SLOW_LAST = 2'h3;
    localparam logic [1:0] DIV_FAST_LAST = 2'h1;
    localparam int SAMPLE_TICKS = 4;
    localparam logic [3:0] MSB_INDEX = 4'h9;

    typedef struct packed {
        logic speed;
        logic conv_on;
        logic [CHAN_BITS-1:0] channel_select;
    } sac_csr_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10
    } sac_state_t;
endpackage : sac_pkg

// *** sac_adc_ctrl.sv ***
// sac_adc_ctrl: apb register slave and successive approximation sequencer
// assumes a comparator that reports input above the driven dac code and an
// analog mux steered by channel_select; all inputs synchronous to pclk.
`timescale 1ns/100ps
module sac_adc_ctrl
    import sac_pkg::*;
#(
    parameter int SAMPLE_LEN = SAMPLE_TICKS
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_BITS-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic halt_mode,
    input wire logic cmp_above,
    input wire logic [15:0] pin_level,
    output logic converter_power,
    output logic sample_hold,
    output logic [RES_BITS-1:0] dac_code,
    output logic [CHAN_BITS-1:0] channel_select
);
    sac_csr_t csr_reg;
    sac_state_t state_reg;
    logic done_reg;
    logic [RES_BITS-1:0] result_reg;
    logic [RES_BITS-1:0] trial_reg;
    logic [3:0] bit_idx_reg;
    logic [7:0] samp_cnt_reg;
    logic [1:0] div_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic power_reg;

    function automatic logic [7:0] reg_index(input logic [ADDR_BITS-1:0] a);
        reg_index = a[9:2];
    endfunction : reg_index

    function automatic logic mapped(input logic [ADDR_BITS-1:0] a);
        logic [7:0] i;
        i = reg_index(a);
        mapped = (a[1:0] == 2'h0) && (a[ADDR_BITS-1:10] == '0)
            && (i >= IDX_CONTROL_STATUS) && (i <= IDX_PIN_LEVEL);
    endfunction : mapped

    // one wait state: prdata is loaded in the first access cycle
    logic access_first;
    logic fire;
    logic wr_csr;
    logic rd_high;
    logic chan_change;
    logic run;
    logic tick;
    logic done_set;
    logic [RES_BITS-1:0] kept;
    logic [7:0] rd_byte;

    assign access_first = psel && penable && !pready_reg;
    assign fire = psel && penable && pready_reg;
    assign wr_csr = fire && pwrite && mapped(paddr)
        && (reg_index(paddr) == IDX_CONTROL_STATUS);
    assign rd_high = fire && !pwrite && mapped(paddr)
        && (reg_index(paddr) == IDX_RESULT_HIGH);
    assign chan_change = wr_csr
        && (pwdata[CHAN_BITS-1:0] != csr_reg.channel_select);
    // halt powers down regardless of converter_on; wait has no input here
    assign run = csr_reg.conv_on && !halt_mode;
    assign tick = (div_reg == (csr_reg.speed ? DIV_FAST_LAST
        : DIV_SLOW_LAST));
    // comparator decides the bit under trial; saturates naturally at the ends
    assign kept = cmp_above ? trial_reg
        : (trial_reg & ~(RES_BITS'(1) << bit_idx_reg));
    assign done_set = run && !chan_change && (state_reg == ST_CONVERT)
        && tick && (bit_idx_reg == 4'h0);

    always_comb
    begin
        rd_byte = 8'h00;
        unique case (reg_index(paddr))
            IDX_CONTROL_STATUS: rd_byte = {done_reg, csr_reg.speed,
                csr_reg.conv_on, 1'b0, csr_reg.channel_select};
            IDX_RESULT_HIGH: rd_byte = result_reg[RES_BITS-1:2];
            IDX_RESULT_LOW: rd_byte = {6'h00, result_reg[1:0]};
            IDX_PIN_LEVEL: rd_byte = pin_level[7:0];
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            pready_reg <= access_first;
            pslverr_reg <= access_first && !mapped(paddr);
            if (access_first && !pwrite && mapped(paddr))
            begin
                if (reg_index(paddr) == IDX_PIN_LEVEL)
                    prdata_reg <= {16'h0000, pin_level};
                else
                    prdata_reg <= {24'h000000, rd_byte};
            end
            else if (access_first)
                prdata_reg <= 32'h0000_0000;
        end
    end

    // control fields; bit 7 and the reserved bit are never stored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            csr_reg <= sac_csr_t'({CSR_RESET[BIT_SPEED], CSR_RESET[BIT_ON],
                CSR_RESET[CHAN_BITS-1:0]});
        else if (wr_csr)
        begin
            csr_reg.speed <= pwdata[BIT_SPEED];
            csr_reg.conv_on <= pwdata[BIT_ON];
            csr_reg.channel_select <= pwdata[CHAN_BITS-1:0];
        end
    end

    // done: set wins over a coincident clear; only polled, no interrupt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done_reg <= 1'b0;
        else if (done_set)
            done_reg <= 1'b1;
        else if (rd_high || wr_csr)
            done_reg <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_reg <= 2'h0;
        else if (!run || chan_change || tick)
            div_reg <= 2'h0;
        else
            div_reg <= div_reg + 2'h1;
    end

    // sequencer: sample window, then one compare per bit, msb first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= ST_IDLE;
            trial_reg <= '0;
            bit_idx_reg <= 4'h0;
            samp_cnt_reg <= 8'h00;
        end
        else if (!run)
        begin
            state_reg <= ST_IDLE;
            trial_reg <= '0;
            bit_idx_reg <= 4'h0;
        end
        else if (chan_change)
        begin
            state_reg <= ST_SAMPLE;
            samp_cnt_reg <= 8'h00;
            trial_reg <= '0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    state_reg <= ST_SAMPLE;
                    samp_cnt_reg <= 8'h00;
                end
                ST_SAMPLE:
                    if (tick)
                    begin
                        if (samp_cnt_reg == 8'(SAMPLE_LEN - 1))
                        begin
                            state_reg <= ST_CONVERT;
                            bit_idx_reg <= MSB_INDEX;
                            trial_reg <= RES_BITS'(1) << MSB_INDEX;
                        end
                        else
                            samp_cnt_reg <= samp_cnt_reg + 8'h01;
                    end
                ST_CONVERT:
                    if (tick)
                    begin
                        if (bit_idx_reg == 4'h0)
                        begin
                            // continuous: straight back to sampling
                            state_reg <= ST_SAMPLE;
                            samp_cnt_reg <= 8'h00;
                            trial_reg <= '0;
                        end
                        else
                        begin
                            bit_idx_reg <= bit_idx_reg - 4'h1;
                            trial_reg <= kept
                                | (RES_BITS'(1) << (bit_idx_reg - 4'h1));
                        end
                    end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // result is not latched against reads; a slow reader sees mixed halves
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            result_reg <= {RESULT_RESET, 2'b00};
        else if (done_set)
            result_reg <= kept;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            power_reg <= 1'b0;
        else
            power_reg <= run;
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign converter_power = power_reg;
    // only the sampling code has bit 0 set, so this stays a plain flop output
    assign sample_hold = state_reg[0];
    assign dac_code = trial_reg;
    assign channel_select = csr_reg.channel_select;
endmodule : sac_adc_ctrl

// *** sac_chk.sv ***
// sac_chk: port assertions for the converter control block
// assumes it is bound to sac_adc_ctrl and sees only its ports
`timescale 1ns/100ps
module sac_chk
    import sac_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_BITS-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic halt_mode,
    input wire logic converter_power,
    input wire logic sample_hold,
    input wire logic [RES_BITS-1:0] dac_code,
    input wire logic [CHAN_BITS-1:0] channel_select
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic wr_csr;
    assign acc = psel && penable && pready;
    assign wr_csr = acc && pwrite
        && paddr == {2'h0, IDX_CONTROL_STATUS, 2'h0};
    low_pad_a: assert property (
        acc && !pwrite && paddr == {2'h0, IDX_RESULT_LOW, 2'h0}
        |-> prdata[31:2] == 30'h0)
        else $error("low result pad not zero");
    csr_pad_a: assert property (
        acc && !pwrite && paddr == {2'h0, IDX_CONTROL_STATUS, 2'h0}
        |-> prdata[31:8] == 24'h0
        && prdata[4] == 1'h0)
        else $error("control pad not zero");
    chan_load_a: assert property (
        wr_csr |=> channel_select == $past(pwdata[3:0]))
        else $error("channel not loaded");
    chan_cause_a: assert property (
        $changed(channel_select) |-> $past(wr_csr))
        else $error("channel changed without write");
    power_on_a: assert property (
        wr_csr && pwdata[BIT_ON] && !halt_mode ##1 !halt_mode
        |=> converter_power)
        else $error("converter not powered");
    power_off_a: assert property (
        wr_csr && !pwdata[BIT_ON] |=> ##1 !converter_power)
        else $error("converter not stopped");
    halt_off_a: assert property (
        halt_mode |=> !converter_power)
        else $error("powered in halt");
    off_idle_a: assert property (
        !converter_power [*2] |-> !sample_hold)
        else $error("sampling while off");
    msb_first_a: assert property (
        $fell(sample_hold) && converter_power
        |-> dac_code == (RES_BITS'(1) << MSB_INDEX))
        else $error("trial does not start at msb");
endmodule : sac_chk

// *** sac_ain.sv ***
// sac_ain: analog sources behind the channel mux, with the comparator
// assumes one 10-bit level per input, set by the bench, held per conversion
`timescale 1ns/100ps
module sac_ain
    import sac_pkg::*;
(
    input wire logic [CHAN_BITS-1:0] channel_select,
    input wire logic [RES_BITS-1:0] dac_code,
    input wire logic [16*RES_BITS-1:0] levels,
    output logic cmp_above
);
    // ideal comparator: no noise, so codes match levels exactly
    assign cmp_above = levels[channel_select*RES_BITS +: RES_BITS]
        >= dac_code;
endmodule : sac_ain

// *** tb_top.sv ***
// tb_top: self-checking bench for the converter control block
// assumes sac_adc_ctrl, sac_ain and sac_chk compiled before it
`timescale 1ns/100ps
module tb_top
    import sac_pkg::*;
;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, halt_mode = 1'h0;
    logic [ADDR_BITS-1:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, cmp_above, converter_power, sample_hold;
    logic [RES_BITS-1:0] dac_code;
    logic [CHAN_BITS-1:0] channel_select;
    logic [15:0] pin_level = 16'ha5c3;
    logic [16*RES_BITS-1:0] levels = 160'h0;
    int num_errors = 0, checked = 0, cyc = 0, t0, t1;
    always #25 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    sac_adc_ctrl #(.SAMPLE_LEN(1)) dut_u (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .halt_mode,
        .cmp_above, .pin_level, .converter_power, .sample_hold, .dac_code,
        .channel_select);
    sac_ain ain_u (.channel_select, .dac_code, .levels, .cmp_above);
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // one idle edge first, so psel is never assigned twice in a step
    task automatic xfer(input logic [7:0] idx, input logic w,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do
            @(posedge pclk);
        while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : xfer
    task automatic poll_done(output int t);
        int s;
        s = cyc;
        rd = 32'h0;
        for (int i = 0; i < 60 && rd[BIT_DONE] !== 1'h1; i++)
            xfer(IDX_CONTROL_STATUS, 1'h0, 32'h0);
        t = cyc - s;
        chk("done", 32'h80, rd & 32'h80);
    endtask : poll_done
    task automatic t_regs;
        for (int i = 0; i < 3; i++)
        begin
            xfer(IDX_CONTROL_STATUS + 8'(i), 1'h0, 32'h0);
            chk("reset", 32'h0, rd);
        end
        xfer(IDX_PIN_LEVEL, 1'h0, 32'h0);
        chk("pins", 32'ha5c3, rd);
        xfer(8'h74, 1'h0, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        xfer(IDX_CONTROL_STATUS, 1'h1, 32'h80);
        xfer(IDX_RESULT_HIGH, 1'h1, 32'h55);
        xfer(IDX_CONTROL_STATUS, 1'h0, 32'h0);
        chk("csr ro", 32'h0, rd);
        xfer(IDX_RESULT_HIGH, 1'h0, 32'h0);
        chk("high ro", 32'h0, rd);
    endtask : t_regs
    // channel always changes, so timing starts from a fresh sample
    task automatic t_conv(input logic [3:0] ch, input logic [9:0] lv,
        input logic sp, output int t);
        levels[ch*RES_BITS +: RES_BITS] <= lv;
        xfer(IDX_CONTROL_STATUS, 1'h1, {24'h0, 1'h0, sp, 2'h2, ch});
        poll_done(t);
        xfer(IDX_RESULT_LOW, 1'h0, 32'h0);
        chk("low", {30'h0, lv[1:0]}, rd);
        xfer(IDX_RESULT_HIGH, 1'h0, 32'h0);
        chk("high", {24'h0, lv[9:2]}, rd);
        xfer(IDX_CONTROL_STATUS, 1'h0, 32'h0);
        chk("done clr", 32'h0, rd & 32'h80);
    endtask : t_conv
    task automatic t_over;
        levels[9:0] <= 10'h155;
        repeat (60) @(posedge pclk);
        xfer(IDX_RESULT_LOW, 1'h0, 32'h0);
        chk("first low", 32'h1, rd);
        levels[9:0] <= 10'h2aa;
        repeat (60) @(posedge pclk);
        xfer(IDX_RESULT_LOW, 1'h0, 32'h0);
        chk("over low", 32'h2, rd);
        xfer(IDX_RESULT_HIGH, 1'h0, 32'h0);
        chk("over high", 32'haa, rd);
    endtask : t_over
    task automatic t_halt;
        levels[59:50] <= 10'h3c0;
        halt_mode <= 1'h1;
        xfer(IDX_CONTROL_STATUS, 1'h1, 32'h65);
        repeat (100) @(posedge pclk);
        xfer(IDX_CONTROL_STATUS, 1'h0, 32'h0);
        chk("halt done", 32'h0, rd & 32'h80);
        chk("halt pwr", 32'h0, {31'h0, converter_power});
        halt_mode <= 1'h0;
        poll_done(t0);
        xfer(IDX_RESULT_HIGH, 1'h0, 32'h0);
        chk("wake high", 32'hf0, rd);
        xfer(IDX_CONTROL_STATUS, 1'h0, 32'h0);
        chk("8bit clr", 32'h0, rd & 32'h80);
        xfer(IDX_CONTROL_STATUS, 1'h1, 32'h05);
        repeat (100) @(posedge pclk);
        xfer(IDX_CONTROL_STATUS, 1'h0, 32'h0);
        chk("off", 32'h05, rd);
    endtask : t_halt
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        report_and_stop();
    end
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        t_regs();
        t_conv(4'h3, 10'h2b7, 1'h0, t0);
        t_conv(4'hf, 10'h3ff, 1'h1, t1);
        chk("rate", 32'h1, {31'h0, t0 >= 44 && t1 <= 30});
        t_conv(4'h0, 10'h000, 1'h1, t1);
        t_over();
        t_halt();
        report_and_stop();
    end
endmodule : tb_top
bind sac_adc_ctrl sac_chk chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .halt_mode(halt_mode), .converter_power(converter_power),
    .sample_hold(sample_hold), .dac_code(dac_code),
    .channel_select(channel_select));
